// ### rtl/lsl_host.sv
`timescale 1ns/1ns
module lsl_host import lsl_pkg::*; (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   lsl_if.host LINK,
   input wire logic [3:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   output logic BUSY_O,
   output logic IRQ_O
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] tx_ff;
   logic [7:0] sent_ff;
   logic [7:0] rx_ff;
   logic [7:0] div_ff;
   logic blank_ff;
   logic [2:0] irq_ff;
   logic [2:0] mask_ff;
   logic fault_ff;
   logic bad_ff;
   logic go;
   logic done_ev;
   logic fault_ev;
   logic bad_ev;
   lsl_state_e st_ff;
   assign go = WR_I && ADDR_I == LSL_A_CTRL && WDATA_I[LSL_CTRL_GO] && st_ff == LSL_IDLE;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         tx_ff <= LSL_ZERO8;
         div_ff <= LSL_DIV_RST;
         blank_ff <= 1'b1;
         mask_ff <= 3'h0;
      end else if (WR_I) begin
         case (ADDR_I)
            LSL_A_DATA: tx_ff <= WDATA_I;
            LSL_A_DIV: div_ff <= (WDATA_I == LSL_ZERO8) ? 8'h01 : WDATA_I;
            LSL_A_MASK: mask_ff <= WDATA_I[2:0];
            LSL_A_CTRL: blank_ff <= WDATA_I[LSL_CTRL_BLANK];
            default: ;
         endcase
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         irq_ff <= 3'h0;
      end else begin
         irq_ff <= ((RD_I && ADDR_I == LSL_A_IRQ) ? 3'h0 : irq_ff) | {bad_ev, fault_ev, done_ev};
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         RDATA_O <= LSL_ZERO8;
      end else if (RD_I) begin
         case (ADDR_I)
            LSL_A_CTRL: RDATA_O <= {6'h00, blank_ff, 1'b0};
            LSL_A_DATA: RDATA_O <= tx_ff;
            LSL_A_RX: RDATA_O <= rx_ff;
            LSL_A_STAT: RDATA_O <= {5'h00, bad_ff, fault_ff, st_ff != LSL_IDLE};
            LSL_A_IRQ: RDATA_O <= {5'h00, irq_ff};
            LSL_A_MASK: RDATA_O <= {5'h00, mask_ff};
            LSL_A_DIV: RDATA_O <= div_ff;
            default: RDATA_O <= LSL_ZERO8;
         endcase
      end else begin
         RDATA_O <= LSL_ZERO8;
      end
   end
   assign IRQ_O = |(irq_ff & mask_ff);
   // ------------------------------------------------------------
   // transfer engine: MSB first, returned word captured
   // ------------------------------------------------------------
   logic [7:0] cnt_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic sclk_ff;
   logic le_ff;
   logic tick;
   assign tick = cnt_ff == div_ff - 8'h01;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I || st_ff == LSL_IDLE || tick) begin
         cnt_ff <= LSL_ZERO8;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         st_ff <= LSL_IDLE;
         sclk_ff <= 1'b0;
         le_ff <= 1'b0;
         bit_ff <= 4'h0;
         sh_ff <= LSL_ZERO8;
         sent_ff <= LSL_ZERO8;
         rx_ff <= LSL_ZERO8;
      end else begin
         case (st_ff)
            LSL_IDLE: if (go) begin
               sh_ff <= tx_ff;
               sent_ff <= tx_ff;
               bit_ff <= 4'h0;
               st_ff <= LSL_CLKLO;
            end
            LSL_CLKLO: if (tick) begin
               // sample returned bit just before the rising edge
               rx_ff <= {rx_ff[6:0], LINK.sdout};
               sclk_ff <= 1'b1;
               st_ff <= LSL_CLKHI;
            end
            LSL_CLKHI: if (tick) begin
               sclk_ff <= 1'b0;
               sh_ff <= {sh_ff[6:0], 1'b0};
               bit_ff <= bit_ff + 4'h1;
               st_ff <= (bit_ff == LSL_BITS_LAST) ? LSL_LATCH : LSL_CLKLO;
            end
            LSL_LATCH: if (tick) begin
               le_ff <= 1'b1;
               st_ff <= LSL_UNLAT;
            end
            LSL_UNLAT: if (tick) begin
               le_ff <= 1'b0;
               st_ff <= LSL_IDLE;
            end
            default: st_ff <= LSL_IDLE;
         endcase
      end
   end
   assign done_ev = st_ff == LSL_UNLAT && tick;
   // status from previous word returned in rx_ff
   logic ok_pair;
   assign ok_pair = rx_ff[LSL_FAULT_HI] == rx_ff[LSL_FAULT_LO];
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         fault_ff <= 1'b0;
         bad_ff <= 1'b0;
      end else if (done_ev) begin
         fault_ff <= ok_pair & rx_ff[LSL_FAULT_HI];
         bad_ff <= !ok_pair;
      end
   end
   logic [7:0] prev_ff;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         prev_ff <= LSL_ZERO8;
      end else if (done_ev) begin
         prev_ff <= sent_ff;
      end
   end
   logic chain_bad;
   assign chain_bad = {rx_ff[7], rx_ff[4:0]} != {prev_ff[7], prev_ff[4:0]};
   assign fault_ev = done_ev && ok_pair && rx_ff[LSL_FAULT_HI];
   assign bad_ev = done_ev && (!ok_pair || chain_bad);
   assign LINK.sclk = sclk_ff;
   assign LINK.sdin = sh_ff[LSL_W-1];
   assign LINK.latch_load = le_ff;
   assign LINK.blank_n = blank_ff;
   assign BUSY_O = st_ff != LSL_IDLE;
endmodule

// ### rtl/lsl_pkg.sv
package lsl_pkg;
   localparam int LSL_W = 8;
   localparam int LSL_FAULT_HI = 6;
   localparam int LSL_FAULT_LO = 5;
   localparam logic [7:0] LSL_ZERO8 = 8'h00;
   // host register offsets
   localparam logic [3:0] LSL_A_CTRL = 4'h0;
   localparam logic [3:0] LSL_A_DATA = 4'h1;
   localparam logic [3:0] LSL_A_RX = 4'h2;
   localparam logic [3:0] LSL_A_STAT = 4'h3;
   localparam logic [3:0] LSL_A_IRQ = 4'h4;
   localparam logic [3:0] LSL_A_MASK = 4'h5;
   localparam logic [3:0] LSL_A_DIV = 4'h6;
   localparam int LSL_CTRL_GO = 0;
   localparam int LSL_CTRL_BLANK = 1;
   localparam int LSL_IRQ_DONE = 0;
   localparam int LSL_IRQ_FAULT = 1;
   localparam int LSL_IRQ_BAD = 2;
   localparam logic [7:0] LSL_DIV_RST = 8'h08;
   localparam logic [3:0] LSL_BITS_LAST = 4'h7;
   typedef enum logic [2:0] {
      LSL_IDLE = 3'b000,
      LSL_CLKLO = 3'b001,
      LSL_CLKHI = 3'b011,
      LSL_LATCH = 3'b010,
      LSL_UNLAT = 3'b110
   } lsl_state_e;
endpackage

// ### rtl/lsl_if.sv
`timescale 1ns/1ns
interface lsl_if;
   logic sclk;
   logic sdin;
   logic latch_load;
   logic blank_n;
   logic sdout;
   modport dev (input sclk, input sdin, input latch_load, input blank_n, output sdout);
   modport host (output sclk, output sdin, output latch_load, output blank_n, input sdout);
endinterface

// ### rtl/lsl_dev.sv
`timescale 1ns/1ns
module lsl_dev import lsl_pkg::*; (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   lsl_if.dev LINK,
   input wire logic [7:0] CUR_LOW_I,
   input wire logic OVERTEMP_I,
   output logic [7:0] LED_SINK_LINES_O,
   output logic [7:0] LED_SINK_OE_O
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [4:0] s1_ff;
   logic [4:0] s2_ff;
   logic sclk_d_ff;
   logic le_d_ff;
   logic [7:0] cl1_ff;
   logic [7:0] cl2_ff;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         cl1_ff <= LSL_ZERO8;
         cl2_ff <= LSL_ZERO8;
      end else begin
         cl1_ff <= CUR_LOW_I;
         cl2_ff <= cl1_ff;
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         s1_ff <= 5'h00;
         s2_ff <= 5'h00;
      end else begin
         s1_ff <= {OVERTEMP_I, LINK.blank_n, LINK.latch_load, LINK.sdin, LINK.sclk};
         s2_ff <= s1_ff;
      end
   end
   logic sclk_s;
   logic sdin_s;
   logic le_s;
   logic blank_n_s;
   logic ot_s;
   assign {ot_s, blank_n_s, le_s, sdin_s, sclk_s} = s2_ff;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         sclk_d_ff <= 1'b0;
         le_d_ff <= 1'b0;
      end else begin
         sclk_d_ff <= sclk_s;
         le_d_ff <= le_s;
      end
   end
   logic sclk_rise;
   logic le_rise;
   assign sclk_rise = sclk_s & ~sclk_d_ff;
   assign le_rise = le_s & ~le_d_ff;
   // ------------------------------------------------------------
   // shift register and fault load
   // ------------------------------------------------------------
   logic [7:0] shift_ff;
   logic [7:0] latch_ff;
   logic [7:0] open_led;
   logic any_open;
   genvar g;
   generate
      for (g = 0; g < LSL_W; g++) begin : g_open
         assign open_led[g] = latch_ff[g] & cl2_ff[g];
      end
   endgenerate
   assign any_open = |open_led;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         shift_ff <= LSL_ZERO8;
      end else if (le_rise) begin
         // latch_ff captures the unmodified pattern on this same edge, because le_s is already high
         shift_ff[LSL_FAULT_HI] <= |(shift_ff & cl2_ff);
         shift_ff[LSL_FAULT_LO] <= |(shift_ff & cl2_ff);
      end else if (sclk_rise) begin
         shift_ff <= {shift_ff[6:0], sdin_s};
      end
   end
   // pattern bits displaced by the fault load, so the latch keeps the pattern
   logic [1:0] pat65_ff;
   logic fl_ff;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         pat65_ff <= 2'h0;
         fl_ff <= 1'b0;
      end else if (le_rise) begin
         pat65_ff <= shift_ff[LSL_FAULT_HI:LSL_FAULT_LO];
         fl_ff <= 1'b1;
      end else if (sclk_rise) begin
         fl_ff <= 1'b0;
      end
   end
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         latch_ff <= LSL_ZERO8;
      end else if (le_s) begin
         latch_ff <= fl_ff ? {shift_ff[7], pat65_ff, shift_ff[4:0]} : shift_ff;
      end
   end
   assign LINK.sdout = shift_ff[LSL_W-1];
   // ------------------------------------------------------------
   // sink outputs
   // ------------------------------------------------------------
   logic [7:0] oe_ff;
   logic on_ok;
   assign on_ok = blank_n_s == 1'b0 && !ot_s;
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         oe_ff <= LSL_ZERO8;
      end else begin
         oe_ff <= on_ok ? latch_ff : LSL_ZERO8;
      end
   end
   assign LED_SINK_OE_O = oe_ff;
   assign LED_SINK_LINES_O = LSL_ZERO8;
   logic unused_any;
   assign unused_any = any_open;
endmodule

// ### dv/lsl_props.sv
`timescale 1ns/1ns
module lsl_props (
   input wire logic REF_CLK_I,
   input wire logic SRST_I,
   input wire logic sclk,
   input wire logic sdin,
   input wire logic latch_load,
   input wire logic blank_n,
   input wire logic sdout
);
   logic sclk_q_ff, ll_q_ff, d6_ff;
   logic [3:0] since_ff, bits_ff;
   logic [1:0] fcnt_ff;
   logic [7:0] m_ff, v_ff;
   wire logic rise = sclk & ~sclk_q_ff;
   wire logic lrise = latch_load & ~ll_q_ff;
   always_ff @(posedge REF_CLK_I) begin
      sclk_q_ff <= SRST_I ? 1'b0 : sclk;
      ll_q_ff <= SRST_I ? 1'b0 : latch_load;
      if (fcnt_ff == 2'h1 && since_ff == 4'h6) d6_ff <= sdout;
   end
   // ----------------------------------------
   // reference shift chain and counters
   // ----------------------------------------
   always_ff @(posedge REF_CLK_I) begin
      if (SRST_I) begin
         since_ff <= 4'hF;
         bits_ff <= 4'h0;
         fcnt_ff <= 2'h3;
         m_ff <= 8'h00;
         v_ff <= 8'hFF;
      end else begin
         if (rise) since_ff <= 4'h0;
         else if (since_ff != 4'hF) since_ff <= since_ff + 4'h1;
         if (lrise) bits_ff <= 4'h0;
         else if (rise) bits_ff <= bits_ff + 4'h1;
         if (lrise) fcnt_ff <= 2'h0;
         else if (rise && fcnt_ff != 2'h3) fcnt_ff <= fcnt_ff + 2'h1;
         if (rise) m_ff <= {m_ff[6:0], sdin};
         if (rise) v_ff <= {v_ff[6:0], 1'b1};
         else if (lrise) v_ff[6:5] <= 2'b00;
      end
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (SRST_I);
   a_reset_link_idle: assert property (disable iff (1'b0) SRST_I |=>
      !sclk && !latch_load && blank_n && !sdout) else $error("link not idle after reset");
   a_sdout_quiet: assert property (since_ff > 4'h6 |-> $stable(sdout))
      else $error("cascade output moved without clock edge");
   a_sdin_steady: assert property (sclk |-> $stable(sdin))
      else $error("serial data moved while clock high");
   a_eight_bits: assert property (lrise |-> bits_ff == 4'h8)
      else $error("load raised without eight bits");
   a_load_no_clock: assert property (latch_load |-> !sclk)
      else $error("serial clock high during load");
   a_load_width: assert property ($rose(latch_load) |-> latch_load [*8] ##1 !latch_load)
      else $error("load pulse width wrong");
   a_chain_data: assert property (since_ff == 4'h6 && v_ff[7] |-> sdout == m_ff[7])
      else $error("cascade bit wrong");
   a_fault_pair: assert property (fcnt_ff == 2'h2 && since_ff == 4'h6 |-> sdout == d6_ff)
      else $error("fault bits differ");
   c_load: cover property (lrise);
   c_fault_out: cover property (fcnt_ff == 2'h2 && since_ff == 4'h6 && sdout);
   c_shift_one: cover property (rise && sdin);
endmodule

// ### dv/lsl_tb.sv
`timescale 1ns/1ns
module lsl_tb import lsl_pkg::*; ;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] cur_low = 8'h00;
   logic ot = 1'b0;
   logic [7:0] rdata, oe, lines, v;
   logic busy, irq;
   int errors = 0;
   int compares = 0;
   logic [7:0] td [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hFF};
   logic [7:0] cl [4] = '{8'h00, 8'hA5, 8'hFF, 8'h00};
   logic [7:0] rx [4] = '{8'h00, 8'h85, 8'h1A, 8'h7C};
   logic [7:0] ir [4] = '{8'h00, 8'h01, 8'h01, 8'h03};
   lsl_if lnk ();
   lsl_host i_lsl_host (.REF_CLK_I(clk), .SRST_I(srst), .LINK(lnk.host), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUSY_O(busy), .IRQ_O(irq));
   lsl_dev i_lsl_dev (.REF_CLK_I(clk), .SRST_I(srst), .LINK(lnk.dev), .CUR_LOW_I(cur_low),
      .OVERTEMP_I(ot), .LED_SINK_LINES_O(lines), .LED_SINK_OE_O(oe));
   lsl_props i_lsl_props (.REF_CLK_I(clk), .SRST_I(srst), .sclk(lnk.sclk), .sdin(lnk.sdin),
      .latch_load(lnk.latch_load), .blank_n(lnk.blank_n), .sdout(lnk.sdout));
   initial forever #5 clk = ~clk;
   task chk(input string n, input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task wrt(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rdt(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task xfer(input logic [7:0] d);
      wrt(LSL_A_DATA, d);
      wrt(LSL_A_CTRL, 8'h01);
      repeat (3) @(posedge clk);
      for (int n = 0; n < 1000 && busy !== 1'b0; n++) @(posedge clk);
      #1;
   endtask
   task settle();
      repeat (8) @(posedge clk);
      #1;
   endtask
   task conclude();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      conclude();
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      #1 chk("oe", oe, 8'h00);
      chk("lines", lines, 8'h00);
      rdt(LSL_A_DIV, v);
      chk("div", v, LSL_DIV_RST);
      rdt(4'hF, v);
      chk("unmapped", v, 8'h00);
      wrt(LSL_A_MASK, 8'h07);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         cur_low <= cl[i];
         xfer(td[i]);
         rdt(LSL_A_RX, v);
         chk("rx", v, rx[i]);
         chk("oe", oe, td[i]);
         chk("irq_o", {7'h00, irq}, 8'h01);
         rdt(LSL_A_IRQ, v);
         if (i > 0) chk("irq", v, ir[i]);
         chk("irq_o", {7'h00, irq}, 8'h00);
      end
      rdt(LSL_A_STAT, v);
      chk("stat", v, 8'h02);
      $display("test chain done");
      wrt(LSL_A_MASK, 8'h00);
      xfer(8'h81);
      chk("irq_o", {7'h00, irq}, 8'h00);
      wrt(LSL_A_MASK, 8'h07);
      #1 chk("irq_o", {7'h00, irq}, 8'h01);
      rdt(LSL_A_IRQ, v);
      ot <= 1'b1;
      settle();
      chk("oe", oe, 8'h00);
      ot <= 1'b0;
      settle();
      chk("oe", oe, 8'h81);
      wrt(LSL_A_CTRL, 8'h02);
      settle();
      chk("oe", oe, 8'h00);
      wrt(LSL_A_CTRL, 8'h00);
      settle();
      chk("oe", oe, 8'h81);
      chk("lines", lines, 8'h00);
      $display("test gating done");
      conclude();
   end
endmodule
